// ---- rtl/aor_pkg.sv ----
// constants and types shared by the over-range detector files
package aor_pkg;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned HOLD_W   = 4;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_ENABLE   = 8'h3A;
  localparam logic [ADDR_W-1:0] ADDR_HOLD     = 8'h3B;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT    = 8'h3C;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_INT_CLR  = 8'h41;
  localparam logic [ADDR_W-1:0] ADDR_INT_EN   = 8'h42;
  localparam logic [ADDR_W-1:0] ADDR_LIVE     = 8'h43;
  localparam logic [ADDR_W-1:0] ADDR_EVT_CNT  = 8'h44;

  // field positions and reset values
  localparam int unsigned ENABLE_BIT      = 0;
  localparam int unsigned HOLD_LSB        = 0;
  localparam int unsigned HOLD_SEL_W      = 2;
  localparam int unsigned INT_W           = 2;
  localparam int unsigned INT_EVENT_BIT   = 0;
  localparam int unsigned INT_RELEASE_BIT = 1;
  localparam int unsigned LIVE_IND_BIT    = 0;
  localparam int unsigned LIVE_HIT_BIT    = 1;
  localparam int unsigned LIVE_CNT_LSB    = 4;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] CNT_MAX   = 8'hFF;

  // extra indicator cycles per hold select code 0..3
  localparam logic [HOLD_W-1:0] HOLD_EXT_0 = 4'h0;
  localparam logic [HOLD_W-1:0] HOLD_EXT_1 = 4'h3;
  localparam logic [HOLD_W-1:0] HOLD_EXT_2 = 4'h7;
  localparam logic [HOLD_W-1:0] HOLD_EXT_3 = 4'hF;

  // limit code is scaled by 128 codes, i.e. shifted left by 7
  localparam int unsigned LIMIT_SHIFT = 7;
  localparam logic signed [SAMPLE_W:0] FULL_POS = 17'sh07FFF;
  localparam logic signed [SAMPLE_W:0] FULL_NEG = -17'sh08000;

  // cycles from a sample at the input to its effect on the indicator
  localparam int unsigned PIPE_LATENCY = 2;

  typedef enum logic [1:0] {
    AOR_HOLD_NONE,
    AOR_HOLD_SHORT,
    AOR_HOLD_MID,
    AOR_HOLD_LONG
  } aor_hold_sel_t;
endpackage

// ---- rtl/aor_limit_cmp.sv ----
// symmetric threshold comparator for one signed sample
`timescale 1ns/1ps
module aor_limit_cmp (
  input  wire logic [aor_pkg::SAMPLE_W-1:0] sample,
  input  wire logic [aor_pkg::DATA_W-1:0]   limitCode,
  output logic                              beyond,
  output logic signed [aor_pkg::SAMPLE_W:0] hiLimit,
  output logic signed [aor_pkg::SAMPLE_W:0] loLimit
);
  logic signed [aor_pkg::SAMPLE_W:0] sampleExt;
  logic signed [aor_pkg::SAMPLE_W:0] scaled;

  assign sampleExt = {sample[aor_pkg::SAMPLE_W-1], sample};
  assign scaled    = $signed({2'b00, limitCode, {aor_pkg::LIMIT_SHIFT{1'b0}}}); // R09

  always_comb begin
    if (limitCode == aor_pkg::READ_ZERO) begin
      // full scale: a sample sitting on either rail counts as clipped
      hiLimit = aor_pkg::FULL_POS; // R10
      loLimit = aor_pkg::FULL_NEG; // R10
      beyond  = (sampleExt >= hiLimit) || (sampleExt <= loLimit); // R10
    end else begin
      hiLimit = scaled; // R09
      loLimit = -scaled; // R09
      beyond  = (sampleExt > hiLimit) || (sampleExt < loLimit); // R04 R08 R09
    end
  end
endmodule

// ---- rtl/aor_stretch.sv ----
// indicator stretcher counted in core clock cycles
`timescale 1ns/1ps
module aor_stretch (
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  input  wire logic                        clear,
  input  wire logic                        hitIn,
  input  wire logic [aor_pkg::HOLD_W-1:0]  holdLen,
  output logic                             stretched,
  output logic [aor_pkg::HOLD_W-1:0]       remain
);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stretched <= 1'b0;
      remain    <= '0;
    end else if (ce) begin
      if (clear) begin
        stretched <= 1'b0;
        remain    <= '0;
      end else if (hitIn) begin
        stretched <= 1'b1; // R04
        remain    <= holdLen; // R11
      end else if (remain != '0) begin
        stretched <= 1'b1; // R05
        remain    <= remain - 1'b1; // R06
      end else begin
        stretched <= 1'b0;
      end
    end
  end

  property p_restart;
    @(posedge core_clk) disable iff (!rstn || !ce)
    (hitIn && !clear) |=> (stretched && remain == $past(holdLen));
  endproperty
  a_restart: assert property (p_restart) else $error("hold count not reloaded on hit"); // R11

  property p_countdown;
    @(posedge core_clk) disable iff (!rstn || !ce)
    (!hitIn && !clear && remain != '0) |=> (stretched && remain == $past(remain) - 1'b1);
  endproperty
  a_countdown: assert property (p_countdown) else $error("hold count did not step down"); // R05 R06
endmodule

// ---- rtl/aor_detector.sv ----
// over-range detector top: registers, threshold compare, hold stretch, pin drive, interrupts
//
// Operation
// R01: with the enable bit at 0, its reset value, detection is off and no indicator is presented.
// R02: with the enable bit at 1, detection runs and the indicator drives the serial data output pin.
// R03: software writes zeros in the reserved bits above each configuration field.
// R04: a sample whose magnitude exceeds the active limit is an over-range event and raises the indicators.
// R05: after the input returns in range the indicator stays up for 0, 3, 7 or 15 more cycles per hold code.
// R06: the hold extension is counted in core sampling clock cycles.
// R07: a fixed pipeline latency lies between a sample and the matching rise or fall of the indicator.
// R08: each 16-bit signed sample is compared with the programmed limits and sets the flag when beyond them.
// R09: a nonzero limit code N gives symmetric limits of plus and minus N times 128 codes.
// R10: a zero limit code, its reset value, gives the full-scale limits +32767 and -32768.
// R11: a new over-range sample during the hold restarts the hold count at its full length.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module aor_detector (
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  // register port
  input  wire logic [aor_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [aor_pkg::DATA_W-1:0]    regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic [aor_pkg::DATA_W-1:0]         regRdata,
  // sample stream from the converter core
  input  wire logic [aor_pkg::SAMPLE_W-1:0]  sampleData,
  input  wire logic                          sampleValid,
  // indicator, pin and interrupt
  output logic                               rangeExcessFlag,
  output logic                               sdoOut,
  output logic                               sdoOe,
  output logic                               irq
);
  ////////////////////////////////////////////////////////////////////////////
  // configuration and status registers
  logic                                rangeDetectEnable;
  aor_pkg::aor_hold_sel_t              indicatorStretchSelect;
  logic [aor_pkg::DATA_W-1:0]          rangeLimitCode;
  logic [aor_pkg::INT_W-1:0]           intEnable;
  logic [aor_pkg::INT_W-1:0]           intStatus;
  logic [aor_pkg::DATA_W-1:0]          eventCount;

  logic                                wrEnable;
  logic                                wrHold;
  logic                                wrLimit;
  logic                                wrIntClr;
  logic                                wrIntEn;

  assign wrEnable = ce && regWr && (regAddr == aor_pkg::ADDR_ENABLE);
  assign wrHold   = ce && regWr && (regAddr == aor_pkg::ADDR_HOLD);
  assign wrLimit  = ce && regWr && (regAddr == aor_pkg::ADDR_LIMIT);
  assign wrIntClr = ce && regWr && (regAddr == aor_pkg::ADDR_INT_CLR);
  assign wrIntEn  = ce && regWr && (regAddr == aor_pkg::ADDR_INT_EN);

  // only the active field bits are kept; reserved bits are expected to be written as zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rangeDetectEnable <= 1'b0; // R01
    end else if (wrEnable) begin
      rangeDetectEnable <= regWdata[aor_pkg::ENABLE_BIT]; // R03
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      indicatorStretchSelect <= aor_pkg::AOR_HOLD_NONE;
    end else if (wrHold) begin
      indicatorStretchSelect <= aor_pkg::aor_hold_sel_t'(
        regWdata[aor_pkg::HOLD_LSB +: aor_pkg::HOLD_SEL_W]); // R03
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rangeLimitCode <= aor_pkg::REG_RESET; // R10
    end else if (wrLimit) begin
      rangeLimitCode <= regWdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      intEnable <= '0;
    end else if (wrIntEn) begin
      intEnable <= regWdata[aor_pkg::INT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold length decode
  logic [aor_pkg::HOLD_W-1:0]          holdLen;

  always_comb begin
    unique case (indicatorStretchSelect)
      aor_pkg::AOR_HOLD_NONE:  holdLen = aor_pkg::HOLD_EXT_0; // R05
      aor_pkg::AOR_HOLD_SHORT: holdLen = aor_pkg::HOLD_EXT_1; // R05
      aor_pkg::AOR_HOLD_MID:   holdLen = aor_pkg::HOLD_EXT_2; // R05
      aor_pkg::AOR_HOLD_LONG:  holdLen = aor_pkg::HOLD_EXT_3; // R05
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold compare, registered as the first pipeline stage
  logic                                sampleBeyond;
  logic signed [aor_pkg::SAMPLE_W:0]   hiLimit;
  logic signed [aor_pkg::SAMPLE_W:0]   loLimit;
  logic                                hitFlag;

  aor_limit_cmp u_cmp (
    .sample    (sampleData),
    .limitCode (rangeLimitCode),
    .beyond    (sampleBeyond),
    .hiLimit   (hiLimit),
    .loLimit   (loLimit)
  );

  // a cycle without a valid sample counts as in range
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hitFlag <= 1'b0;
    end else if (ce) begin
      hitFlag <= rangeDetectEnable && sampleValid && sampleBeyond; // R01 R04 R07 R08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold stretch, second pipeline stage
  logic                                stretched;
  logic [aor_pkg::HOLD_W-1:0]          remain;

  aor_stretch u_stretch (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .ce        (ce),
    .clear     (!rangeDetectEnable),
    .hitIn     (hitFlag),
    .holdLen   (holdLen),
    .stretched (stretched),
    .remain    (remain)
  );

  assign rangeExcessFlag = stretched; // R07
  assign sdoOut          = stretched; // R02
  assign sdoOe           = rangeDetectEnable; // R01 R02

  ////////////////////////////////////////////////////////////////////////////
  // events and interrupts
  logic                                stretchedDly;
  logic                                evtStart;
  logic                                evtRelease;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stretchedDly <= 1'b0;
    end else if (ce) begin
      stretchedDly <= stretched;
    end
  end

  assign evtStart   = stretched && !stretchedDly;
  assign evtRelease = !stretched && stretchedDly;

  // an event in the same cycle as its clear keeps the bit set
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      intStatus <= '0;
    end else if (ce) begin
      intStatus[aor_pkg::INT_EVENT_BIT] <= evtStart ||
        (intStatus[aor_pkg::INT_EVENT_BIT] && !(wrIntClr && regWdata[aor_pkg::INT_EVENT_BIT]));
      intStatus[aor_pkg::INT_RELEASE_BIT] <= evtRelease ||
        (intStatus[aor_pkg::INT_RELEASE_BIT] && !(wrIntClr && regWdata[aor_pkg::INT_RELEASE_BIT]));
    end
  end

  assign irq = |(intStatus & intEnable);

  // saturating count of indicator rises, cleared by clearing the event status bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      eventCount <= aor_pkg::REG_RESET;
    end else if (ce) begin
      if (evtStart && eventCount != aor_pkg::CNT_MAX) begin
        eventCount <= eventCount + 1'b1;
      end else if (!evtStart && wrIntClr && regWdata[aor_pkg::INT_EVENT_BIT]) begin
        eventCount <= aor_pkg::REG_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: data one cycle after the read strobe, unmapped reads return zero
  logic [aor_pkg::DATA_W-1:0]          next_regRdata;
  logic [aor_pkg::DATA_W-1:0]          liveWord;

  always_comb begin
    liveWord = aor_pkg::READ_ZERO;
    liveWord[aor_pkg::LIVE_IND_BIT] = stretched;
    liveWord[aor_pkg::LIVE_HIT_BIT] = hitFlag;
    liveWord[aor_pkg::LIVE_CNT_LSB +: aor_pkg::HOLD_W] = remain;
  end

  always_comb begin
    next_regRdata = aor_pkg::READ_ZERO;
    unique case (regAddr)
      aor_pkg::ADDR_ENABLE: next_regRdata[aor_pkg::ENABLE_BIT] = rangeDetectEnable;
      aor_pkg::ADDR_HOLD:
        next_regRdata[aor_pkg::HOLD_LSB +: aor_pkg::HOLD_SEL_W] = indicatorStretchSelect;
      aor_pkg::ADDR_LIMIT:    next_regRdata = rangeLimitCode;
      aor_pkg::ADDR_INT_STAT: next_regRdata[aor_pkg::INT_W-1:0] = intStatus;
      aor_pkg::ADDR_INT_EN:   next_regRdata[aor_pkg::INT_W-1:0] = intEnable;
      aor_pkg::ADDR_LIVE:     next_regRdata = liveWord;
      aor_pkg::ADDR_EVT_CNT:  next_regRdata = eventCount;
      default:                next_regRdata = aor_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= aor_pkg::READ_ZERO;
    end else if (ce) begin
      regRdata <= regRd ? next_regRdata : aor_pkg::READ_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_disabled_quiet;
    @(posedge core_clk) disable iff (!rstn)
    (ce && !rangeDetectEnable && !(wrEnable && regWdata[aor_pkg::ENABLE_BIT])) |=> (!rangeExcessFlag && !sdoOe);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("indicator active while disabled"); // R01

  property p_pin_drive;
    @(posedge core_clk) disable iff (!rstn || !ce)
    (rangeDetectEnable && sampleValid && sampleBeyond) ##1 (rangeDetectEnable && !wrEnable) |=> (sdoOut && sdoOe);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven with indicator"); // R02

  property p_latency_rise;
    @(posedge core_clk) disable iff (!rstn || !ce)
    (rangeDetectEnable && sampleValid && sampleBeyond) ##1 rangeDetectEnable |=> rangeExcessFlag;
  endproperty
  a_latency_rise: assert property (p_latency_rise) else $error("indicator late after over-range sample"); // R07

  property p_hit_stage;
    @(posedge core_clk) disable iff (!rstn || !ce)
    (rangeDetectEnable && sampleValid && sampleData == 16'h7FFF) |=> hitFlag;
  endproperty
  a_hit_stage: assert property (p_hit_stage) else $error("positive rail sample not flagged"); // R08

  // helper for the long hold checks: counts enabled quiet cycles since the last hit
  localparam int unsigned QUIET_LONG = aor_pkg::HOLD_EXT_3 + 1;
  logic [aor_pkg::HOLD_W:0]            quietRun;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      quietRun <= '0;
    end else if (ce) begin
      if (!rangeDetectEnable || indicatorStretchSelect != aor_pkg::AOR_HOLD_LONG) begin
        quietRun <= '0;
      end else if (hitFlag) begin
        quietRun <= {{aor_pkg::HOLD_W{1'b0}}, 1'b1};
      end else if (quietRun != '0 && quietRun <= QUIET_LONG) begin
        quietRun <= quietRun + 1'b1;
      end
    end
  end

  property p_hold_long;
    @(posedge core_clk) disable iff (!rstn || !ce || !rangeDetectEnable)
    (quietRun == QUIET_LONG) |-> (rangeExcessFlag && remain == '0);
  endproperty
  a_hold_long: assert property (p_hold_long) else $error("long hold not fifteen cycles"); // R05

  property p_hold_long_end;
    @(posedge core_clk) disable iff (!rstn || !ce || !rangeDetectEnable)
    (quietRun == QUIET_LONG && !hitFlag) |=> !rangeExcessFlag;
  endproperty
  a_hold_long_end: assert property (p_hold_long_end) else $error("long hold ran past fifteen cycles"); // R05

  property p_hold_none;
    @(posedge core_clk) disable iff (!rstn || !ce || !rangeDetectEnable)
    (hitFlag && indicatorStretchSelect == aor_pkg::AOR_HOLD_NONE) ##1 !hitFlag |=> !rangeExcessFlag;
  endproperty
  a_hold_none: assert property (p_hold_none) else $error("indicator stretched with zero hold"); // R05

  property p_limit_scale;
    @(posedge core_clk) disable iff (!rstn)
    (rangeLimitCode != 8'h00) |-> (hiLimit == $signed({9'h000, rangeLimitCode}) * 128 && loLimit == -hiLimit);
  endproperty
  a_limit_scale: assert property (p_limit_scale) else $error("scaled limit wrong"); // R09

  property p_limit_full;
    @(posedge core_clk) disable iff (!rstn)
    (rangeLimitCode == 8'h00) |-> (hiLimit == 17'sh07FFF && loLimit == -17'sh08000);
  endproperty
  a_limit_full: assert property (p_limit_full) else $error("full scale limit wrong"); // R10

  property p_sticky_event;
    @(posedge core_clk) disable iff (!rstn || !ce)
    evtStart |=> intStatus[aor_pkg::INT_EVENT_BIT];
  endproperty
  a_sticky_event: assert property (p_sticky_event) else $error("event status bit lost"); // R04

  property p_release_event;
    @(posedge core_clk) disable iff (!rstn || !ce)
    evtRelease |=> intStatus[aor_pkg::INT_RELEASE_BIT];
  endproperty
  a_release_event: assert property (p_release_event) else $error("release status bit lost"); // R05

  property p_hold_short;
    @(posedge core_clk) disable iff (!rstn || !ce || !rangeDetectEnable)
    (hitFlag && indicatorStretchSelect == aor_pkg::AOR_HOLD_SHORT) ##1
      (!hitFlag && indicatorStretchSelect == aor_pkg::AOR_HOLD_SHORT) [*3] |=> (rangeExcessFlag && remain == '0);
  endproperty
  a_hold_short: assert property (p_hold_short) else $error("short hold not three cycles"); // R05

  property p_hold_mid;
    @(posedge core_clk) disable iff (!rstn || !ce || !rangeDetectEnable)
    (hitFlag && indicatorStretchSelect == aor_pkg::AOR_HOLD_MID) ##1
      (!hitFlag && indicatorStretchSelect == aor_pkg::AOR_HOLD_MID) [*7] |=> (rangeExcessFlag && remain == '0);
  endproperty
  a_hold_mid: assert property (p_hold_mid) else $error("mid hold not seven cycles"); // R05

  property p_no_hit_disabled;
    @(posedge core_clk) disable iff (!rstn)
    (ce && !rangeDetectEnable) |=> !hitFlag;
  endproperty
  a_no_hit_disabled: assert property (p_no_hit_disabled) else $error("hit stage set while disabled"); // R01

  property p_invalid_quiet;
    @(posedge core_clk) disable iff (!rstn)
    (ce && !sampleValid) |=> !hitFlag;
  endproperty
  a_invalid_quiet: assert property (p_invalid_quiet) else $error("hit stage set without a valid sample"); // R04

  property p_neg_rail;
    @(posedge core_clk) disable iff (!rstn || !ce)
    (rangeDetectEnable && sampleValid && sampleData == 16'h8000) |=> hitFlag;
  endproperty
  a_neg_rail: assert property (p_neg_rail) else $error("negative rail sample not flagged"); // R08

  property p_full_inside;
    @(posedge core_clk) disable iff (!rstn || !ce)
    (rangeDetectEnable && sampleValid && rangeLimitCode == 8'h00 && sampleData == 16'h7FFE) |=> !hitFlag;
  endproperty
  a_full_inside: assert property (p_full_inside) else $error("in-range sample flagged at full scale"); // R10
endmodule

// ---- dv/aor_sample_src.sv ----
// converter core model that feeds one signed sample per cycle to the detector
`timescale 1ns/1ps
module aor_sample_src (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] reqData,
  input  wire logic        reqValid,
  output logic [15:0]      sampleData,
  output logic             sampleValid
);
  ////////////////////////////////////////////////////////////////////////////////
  // registered sample launch; an idle cycle shows the inverted last word, not stale data
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sampleData  <= 16'h5A5A;
      sampleValid <= 1'b0;
    end else begin
      sampleValid <= reqValid;
      sampleData  <= reqValid ? reqData : ~sampleData;
    end
  end
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the over-range detector
`timescale 1ns/1ps
module tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWdata = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [7:0]  regRdata;
  logic [15:0] reqData = 16'h0000;
  logic        reqValid = 1'b0;
  logic [15:0] sampleData;
  logic        sampleValid;
  logic        rangeExcessFlag, sdoOut, sdoOe, irq;
  logic        mEn = 1'b0, chkOn = 1'b0, hitQ, expFlag;
  logic [1:0]  mHold = 2'h0;
  logic [7:0]  mLim = 8'h00;
  logic [3:0]  cnt;
  int          n_fail = 0, compares = 0, rises = 0, falls = 0;

  aor_sample_src aor_sample_src_inst (.core_clk(core_clk), .rstn(rstn), .reqData(reqData), .reqValid(reqValid),
    .sampleData(sampleData), .sampleValid(sampleValid));
  aor_detector aor_detector_inst (.core_clk(core_clk), .rstn(rstn), .ce(ce), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sampleData(sampleData),
    .sampleValid(sampleValid), .rangeExcessFlag(rangeExcessFlag), .sdoOut(sdoOut), .sdoOe(sdoOe), .irq(irq));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference behaviour
  function automatic logic beyondF(input logic [15:0] s, input logic [7:0] code);
    int v, lim;
    v = $signed(s);
    lim = int'(code) * 128;
    if (code == 8'h00) return (v >= 32767) || (v <= -32768);
    return (v > lim) || (v < -lim);
  endfunction

  function automatic logic [3:0] holdExt(input logic [1:0] sel);
    case (sel)
      2'h0: return 4'h0;
      2'h1: return 4'h3;
      2'h2: return 4'h7;
      default: return 4'hF;
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hitQ    <= 1'b0;
      expFlag <= 1'b0;
      cnt     <= 4'h0;
    end else if (ce) begin
      hitQ <= mEn && sampleValid && beyondF(sampleData, mLim);
      if (!mEn) begin
        expFlag <= 1'b0;
        cnt     <= 4'h0;
      end else if (hitQ) begin
        expFlag <= 1'b1;
        cnt     <= holdExt(mHold);
      end else if (cnt != 4'h0) begin
        expFlag <= 1'b1;
        cnt     <= cnt - 4'h1;
      end else begin
        expFlag <= 1'b0;
      end
    end
  end

  always @(posedge expFlag) rises++;
  always @(negedge expFlag) falls++;

  ////////////////////////////////////////////////////////////////////////////////
  // comparisons and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  always @(negedge core_clk) begin
    if (chkOn) begin
      check({7'h0, rangeExcessFlag}, {7'h0, expFlag});
      check({7'h0, sdoOut}, {7'h0, expFlag});
      check({7'h0, sdoOe}, {7'h0, mEn});
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // bus and stream drivers
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    ce       <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    if (a == aor_pkg::ADDR_ENABLE) mEn <= d[0];
    if (a == aor_pkg::ADDR_HOLD) mHold <= d[1:0];
    if (a == aor_pkg::ADDR_LIMIT) mLim <= d;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    ce      <= 1'b1;
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ce       <= 1'b1;
      reqValid <= 1'b0;
    end
  endtask

  task automatic stream(input int n);
    int lim;
    lim = (mLim == 8'h00) ? 32767 : int'(mLim) * 128;
    repeat (n) begin
      @(posedge core_clk);
      ce       <= ($urandom % 8) != 0;
      reqValid <= ($urandom % 6) != 0;
      case ($urandom % 8)
        0: reqData <= 16'(lim);
        1: reqData <= 16'(-lim);
        2: reqData <= 16'(lim + 1);
        3: reqData <= 16'(-lim - 1);
        4: reqData <= 16'(lim - 1);
        default: reqData <= 16'($urandom);
      endcase
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  logic [7:0] rd, ie;
  logic [7:0] resetAddr [8] = '{8'h3A, 8'h3B, 8'h3C, 8'h40, 8'h41, 8'h42, 8'h44, 8'h50};
  logic [7:0] limTab [7] = '{8'h00, 8'h01, 8'h80, 8'hFF, 8'h02, 8'hFE, 8'h00};

  initial begin
    void'($urandom(82479));
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    chkOn = 1'b1;
    foreach (resetAddr[i]) begin
      regRead(resetAddr[i], rd);
      check(rd, 8'h00);
    end
    for (int p = 0; p < 12; p++) begin
      idle(20);
      regWrite(aor_pkg::ADDR_ENABLE, {7'h00, p != 3});
      regWrite(aor_pkg::ADDR_HOLD, {6'h00, 2'(p % 4)});
      regWrite(aor_pkg::ADDR_LIMIT, (p > 6) ? 8'($urandom) : limTab[p]);
      regRead(aor_pkg::ADDR_ENABLE, rd);
      check(rd, {7'h00, mEn});
      regRead(aor_pkg::ADDR_HOLD, rd);
      check(rd, {6'h00, mHold});
      regRead(aor_pkg::ADDR_LIMIT, rd);
      check(rd, mLim);
      regWrite(aor_pkg::ADDR_INT_CLR, 8'h03);
      idle(3);
      rises = 0;
      falls = 0;
      stream(300);
      idle(25);
      regRead(aor_pkg::ADDR_INT_STAT, rd);
      check(rd, {6'h00, falls > 0, rises > 0});
      regRead(aor_pkg::ADDR_EVT_CNT, rd);
      check(rd, (rises > 255) ? 8'hFF : 8'(rises));
      regRead(aor_pkg::ADDR_LIVE, rd);
      check(rd, 8'h00);
      ie = 8'($urandom % 4);
      regWrite(aor_pkg::ADDR_INT_EN, ie);
      #1 check({7'h00, irq}, {7'h00, |(ie[1:0] & {falls > 0, rises > 0})});
      regWrite(aor_pkg::ADDR_INT_CLR, 8'h03);
      #1 check({7'h00, irq}, 8'h00);
      regRead(aor_pkg::ADDR_INT_STAT, rd);
      check(rd, 8'h00);
      regRead(aor_pkg::ADDR_EVT_CNT, rd);
      check(rd, 8'h00);
    end
    test_done();
  end
endmodule
